// >>> hdl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] val;
   } sync_t;

   sync_t s_q;
   sync_t s_d;

   // A change counts only once the second and third stages agree
   always_comb begin
      s_d    = s_q;
      s_d.s1 = din;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      for (int i = 0; i < W; i++) begin
         if (s_q.s2[i] == s_q.s3[i]) begin
            s_d.val[i] = s_q.s3[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.val;

endmodule : pin_sync

// >>> hdl/tx_level_control.sv
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - Fixed bit set: attenuation follows the written three-bit code, loop leaves it alone.
// - Eight attenuation codes, 3 dB apart, code 0 is 0 dB, code 7 is -21 dB.
// - Fixed bit clear: level is set automatically from the sensed peak.
// - Peak below low threshold raises level a step, above high lowers it.
// - One chip clock evaluates, the next applies the new gain.
// - Loop runs only for the first 16 chip clocks after entering transmit.
// - Reset leaves the level at minimum, the largest attenuation.
// - Level is retained through receive; next frame starts from it.
// - Transmit-enable output is driven low while transmitting, released otherwise.
// - After transmit ends, transmit-enable stays low a short extra time.
// - Overcurrent flag high means load current reached the limit.
// - Overcurrent flag low again once the current recovers.
// - Amplifier runs only while its enable input is low.
// - Overtemperature disables the amplifier; it returns when cleared and still enabled.
// - Chip clock from the PLL runs at eight times the bit rate.
// - Mode flag high selects transmit, low selects receive.
module tx_level_control
   import tx_level_pkg::*;
#(
   parameter int LOOP_LEN  = LOOP_CHIPS,
   parameter int HOLD_CYC  = TXEN_HOLD_CYC
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [DATA_W-1:0] rd_data,
   input  wire logic              chip_clk_pin,
   input  wire logic              peak_below_low,
   input  wire logic              peak_above_high,
   input  wire logic              overcurrent_flag,
   input  wire logic              over_temp,
   input  wire logic              driver_enable_n,
   output logic      [CODE_W-1:0] attenuation_code,
   output logic                   transmit_active_n_out,
   output logic                   transmit_active_n_oe,
   output logic                   amp_enable,
   output logic                   irq
);

   typedef struct packed {
      logic [CTRL_W-1:0] lvl_ctrl;
      logic              mode;
      logic [IRQ_W-1:0]  mask;
      logic [IRQ_W-1:0]  irq_st;
      logic [CODE_W-1:0] level;
      logic [WIN_W-1:0]  win_cnt;
      loop_phase_t       phase;
      logic              step_up;
      logic              step_dn;
      logic [HOLD_W-1:0] hold_cnt;
      logic              mode_prev;
      logic              chip_prev;
      logic              oc_prev;
      logic              ot_prev;
      logic [DATA_W-1:0] rd_data;
      logic              txa_out;
      logic              txa_oe;
      logic              amp_en;
      logic              irq;
   } state_t;

   state_t            s_q;
   state_t            s_d;
   logic [SYNC_W-1:0] sy;
   logic              chip_rise;
   logic              mode_rise;
   logic              mode_fall;
   logic              fixed;
   logic [IRQ_W-1:0]  irq_set;
   logic [IRQ_W-1:0]  irq_clr;
   logic [DATA_W-1:0] status_word;

   // All pins from the analogue side and the PLL cross into clk here
   pin_sync #(
      .W    (SYNC_W)
   ) u_sync (
      .clk  (clk),
      .rst_n(rst_n),
      // Enable inverted before sync so the reset value of the stage means amplifier off
      .din  ({~driver_enable_n, over_temp, overcurrent_flag,
              peak_above_high, peak_below_low, chip_clk_pin}),
      .dout (sy)
   );

   // Chip clock is slow against clk, so an edge detect suffices
   assign chip_rise = sy[SY_CHIP] & ~s_q.chip_prev;
   assign mode_rise = s_q.mode & ~s_q.mode_prev;
   assign mode_fall = ~s_q.mode & s_q.mode_prev;
   assign fixed     = s_q.lvl_ctrl[FIXED_BIT];

   always_comb begin
      status_word              = '0;
      status_word[CODE_W-1:0]  = s_q.level;
      status_word[ST_OC]       = sy[SY_OC];
      status_word[ST_OT]       = sy[SY_OT];
      status_word[ST_LOOP]     = (s_q.win_cnt != '0);
      status_word[ST_TX]       = s_q.mode;
   end

   always_comb begin
      irq_set                  = '0;
      irq_set[IRQ_OVERCURRENT] = sy[SY_OC] & ~s_q.oc_prev;
      irq_set[IRQ_OVERTEMP]    = sy[SY_OT] & ~s_q.ot_prev;
      irq_set[IRQ_LOOP_DONE]   = chip_rise & ~fixed & (s_q.win_cnt == WIN_W'(1));
      irq_clr                  = '0;
      if (wr_en && addr == ADDR_IRQ_STATUS) begin
         irq_clr = wr_data[IRQ_W-1:0];
      end
   end

   always_comb begin
      s_d           = s_q;
      s_d.chip_prev = sy[SY_CHIP];
      s_d.oc_prev   = sy[SY_OC];
      s_d.ot_prev   = sy[SY_OT];
      s_d.mode_prev = s_q.mode;

      if (wr_en) begin
         case (addr)
            ADDR_LEVEL_CTRL: begin
               s_d.lvl_ctrl = wr_data[CTRL_W-1:0];
            end
            ADDR_MODE: begin
               s_d.mode = wr_data[MODE_BIT];
            end
            ADDR_IRQ_MASK: begin
               s_d.mask = wr_data[IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // Set wins over a clear in the same cycle
      s_d.irq_st = (s_q.irq_st & ~irq_clr) | irq_set;

      if (fixed) begin
         s_d.level   = s_q.lvl_ctrl[CODE_W-1:0];
         s_d.phase   = PH_EVAL;
         s_d.step_up = 1'b0;
         s_d.step_dn = 1'b0;
         if (chip_rise && s_q.win_cnt != '0) begin
            s_d.win_cnt = s_q.win_cnt - WIN_W'(1);
         end
      // Leaving transmit stops the loop at once, even between evaluate and apply
      end else if (chip_rise && s_q.win_cnt != '0 && s_q.mode) begin
         s_d.win_cnt = s_q.win_cnt - WIN_W'(1);
         case (s_q.phase)
            PH_EVAL: begin
               // Sampled once here; outside the window nothing looks at them
               s_d.step_up = sy[SY_BELOW];
               s_d.step_dn = sy[SY_ABOVE] & ~sy[SY_BELOW];
               s_d.phase   = PH_APPLY;
            end
            PH_APPLY: begin
               if (s_q.step_up && s_q.level != CODE_MAX_GAIN) begin
                  s_d.level = s_q.level - CODE_STEP;
               end else if (s_q.step_dn && s_q.level != CODE_MIN_GAIN) begin
                  s_d.level = s_q.level + CODE_STEP;
               end
               s_d.phase = PH_EVAL;
            end
            default: begin
               s_d.phase = PH_EVAL;
            end
         endcase
      end

      // Window opens on every entry to transmit, closes on leaving it
      if (mode_rise) begin
         s_d.win_cnt = WIN_W'(LOOP_LEN);
         s_d.phase   = PH_EVAL;
      end else if (!s_q.mode) begin
         s_d.win_cnt = '0;
      end

      // Hold keeps the external driver on while the last sine dies out
      if (mode_fall) begin
         s_d.hold_cnt = HOLD_W'(HOLD_CYC);
      end else if (s_q.hold_cnt != '0) begin
         s_d.hold_cnt = s_q.hold_cnt - HOLD_W'(1);
      end
      s_d.txa_out = 1'b0;
      s_d.txa_oe  = s_q.mode | mode_fall | (s_q.hold_cnt > HOLD_W'(1));

      // Amplifier needs its low enable and no thermal shutdown
      s_d.amp_en = sy[SY_DRV] & ~sy[SY_OT];

      s_d.irq = |(s_d.irq_st & s_d.mask);

      s_d.rd_data = '0;
      if (rd_en) begin
         case (addr)
            ADDR_LEVEL_CTRL: begin
               s_d.rd_data[CTRL_W-1:0] = s_q.lvl_ctrl;
            end
            ADDR_MODE: begin
               s_d.rd_data[MODE_BIT] = s_q.mode;
            end
            ADDR_STATUS: begin
               s_d.rd_data = status_word;
            end
            ADDR_IRQ_STATUS: begin
               s_d.rd_data[IRQ_W-1:0] = s_q.irq_st;
            end
            ADDR_IRQ_MASK: begin
               s_d.rd_data[IRQ_W-1:0] = s_q.mask;
            end
            default: begin
               s_d.rd_data = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q          <= '0;
         s_q.lvl_ctrl <= LEVEL_CTRL_RST;
         s_q.mask     <= IRQ_MASK_RST;
         s_q.level    <= CODE_MIN_GAIN;
         s_q.phase    <= PH_EVAL;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_data               = s_q.rd_data;
   assign attenuation_code      = s_q.level;
   assign transmit_active_n_out = s_q.txa_out;
   assign transmit_active_n_oe  = s_q.txa_oe;
   assign amp_enable            = s_q.amp_en;
   assign irq                   = s_q.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_fixed_level: assert property (fixed |=> s_q.level == $past(s_q.lvl_ctrl[CODE_W-1:0]))
      else $error("fixed mode level does not follow code");

   a_step_one: assert property (!$past(fixed) && s_q.level != $past(s_q.level)
      |-> ({1'b0, s_q.level} == {1'b0, $past(s_q.level)} + 4'h1) ||
          ({1'b0, $past(s_q.level)} == {1'b0, s_q.level} + 4'h1))
      else $error("automatic level moved by more than one step");

   a_apply_phase: assert property (!$past(fixed) && s_q.level != $past(s_q.level)
      |-> $past(chip_rise) && $past(s_q.phase) == PH_APPLY)
      else $error("level changed outside an apply chip clock");

   a_loop_window: assert property (!$past(fixed) && s_q.level != $past(s_q.level)
      |-> $past(s_q.win_cnt) != '0 && $past(s_q.mode))
      else $error("level changed outside the loop window");

   a_level_retain: assert property (!s_q.mode && !fixed ##1 !s_q.mode && !fixed
      |-> $stable(s_q.level))
      else $error("level changed during receive");

   a_txen_active: assert property (s_q.mode |=> transmit_active_n_oe && !transmit_active_n_out)
      else $error("transmit enable not driven low in transmit");

   a_txen_hold: assert property ($fell(s_q.mode) |-> transmit_active_n_oe [*8])
      else $error("transmit enable released too early");

   a_amp_thermal: assert property (sy[SY_OT] |=> !amp_enable)
      else $error("amplifier on during overtemperature");

   a_amp_enable: assert property (amp_enable |-> $past(sy[SY_DRV]))
      else $error("amplifier on without enable");

   a_oc_event: assert property (sy[SY_OC] && !s_q.oc_prev |=> s_q.irq_st[IRQ_OVERCURRENT])
      else $error("overcurrent event lost");

   a_irq_out: assert property (irq == |(s_q.irq_st & s_q.mask))
      else $error("interrupt output disagrees with status and mask");

   a_ctrl_write: assert property (wr_en && addr == ADDR_LEVEL_CTRL |=> s_q.lvl_ctrl == $past(wr_data[CTRL_W-1:0]))
      else $error("level control write lost");

   a_mode_write: assert property (wr_en && addr == ADDR_MODE |=> s_q.mode == $past(wr_data[MODE_BIT]))
      else $error("mode write lost");

   a_rd_idle: assert property (!rd_en |=> rd_data == '0)
      else $error("read data not zero outside a read");

   a_rd_unmapped: assert property (rd_en && addr > ADDR_IRQ_MASK |=> rd_data == '0)
      else $error("unmapped read not zero");

   a_rd_status: assert property (rd_en && addr == ADDR_STATUS |=> rd_data[CODE_W-1:0] == $past(s_q.level))
      else $error("status read does not show the level code");

   a_window_open: assert property (mode_rise |=> s_q.win_cnt == WIN_W'(LOOP_LEN))
      else $error("loop window not opened on entry to transmit");

   a_window_closed: assert property (!s_q.mode_prev |-> s_q.win_cnt == '0)
      else $error("loop window open in receive");

   a_window_bound: assert property (s_q.win_cnt <= WIN_W'(LOOP_LEN))
      else $error("loop window longer than allowed");

   a_loop_done: assert property (chip_rise && !fixed && s_q.win_cnt == WIN_W'(1) |=> s_q.irq_st[IRQ_LOOP_DONE])
      else $error("loop done event lost");

   a_eval_still: assert property (chip_rise && !fixed && s_q.phase == PH_EVAL |=> s_q.level == $past(s_q.level))
      else $error("level moved on an evaluate chip clock");

   a_step_raise: assert property (chip_rise && !fixed && s_q.mode && s_q.win_cnt != '0
      && s_q.phase == PH_APPLY && s_q.step_up && s_q.level != CODE_MAX_GAIN |=> s_q.level == $past(s_q.level) - CODE_STEP)
      else $error("level not raised by one step");

   a_step_lower: assert property (chip_rise && !fixed && s_q.mode && s_q.win_cnt != '0
      && s_q.phase == PH_APPLY && s_q.step_dn && !s_q.step_up && s_q.level != CODE_MIN_GAIN |=> s_q.level == $past(s_q.level) + CODE_STEP)
      else $error("level not lowered by one step");

   a_no_wrap_top: assert property (!fixed && s_q.level == CODE_MAX_GAIN |=> s_q.level != CODE_MIN_GAIN)
      else $error("level wrapped past 0 dB");

   a_no_wrap_bottom: assert property (!fixed && s_q.level == CODE_MIN_GAIN |=> s_q.level != CODE_MAX_GAIN)
      else $error("level wrapped past the largest attenuation");

   a_ot_event: assert property (sy[SY_OT] && !s_q.ot_prev |=> s_q.irq_st[IRQ_OVERTEMP])
      else $error("overtemperature event lost");

   a_oc_sticky: assert property (s_q.irq_st[IRQ_OVERCURRENT] && !irq_clr[IRQ_OVERCURRENT] |=> s_q.irq_st[IRQ_OVERCURRENT])
      else $error("overcurrent status lost without a clear");

   a_hold_load: assert property (mode_fall |=> s_q.hold_cnt == HOLD_W'(HOLD_CYC))
      else $error("transmit enable hold not started");

   a_txen_release: assert property (!s_q.mode && !mode_fall && s_q.hold_cnt <= HOLD_W'(1) |=> !transmit_active_n_oe)
      else $error("transmit enable not released");

   a_txen_pull: assert property (transmit_active_n_oe |-> !transmit_active_n_out)
      else $error("transmit enable driven high");

   a_amp_return: assert property (sy[SY_DRV] && !sy[SY_OT] |=> amp_enable)
      else $error("amplifier not re-enabled");

endmodule : tx_level_control

// >>> hdl/tx_level_pkg.sv
package tx_level_pkg;

   // Register port geometry
   localparam int          ADDR_W            = 3;
   localparam int          DATA_W            = 8;

   // Register offsets
   localparam logic [2:0]  ADDR_LEVEL_CTRL   = 3'h0;
   localparam logic [2:0]  ADDR_MODE         = 3'h1;
   localparam logic [2:0]  ADDR_STATUS       = 3'h2;
   localparam logic [2:0]  ADDR_IRQ_STATUS   = 3'h3;
   localparam logic [2:0]  ADDR_IRQ_MASK     = 3'h4;

   // Level control layout
   localparam int          CTRL_W            = 4;
   localparam int          FIXED_BIT         = 3;
   localparam int          CODE_W            = 3;
   localparam logic [3:0]  LEVEL_CTRL_RST    = 4'h0;
   localparam int          MODE_BIT          = 0;

   // Attenuation code: 0 is 0 dB, each step adds 3 dB
   localparam int          ATTEN_STEP_DB     = 3;
   localparam int          ATTEN_MAX_DB      = 21;
   localparam logic [2:0]  CODE_MAX_GAIN     = 3'h0;
   localparam logic [2:0]  CODE_MIN_GAIN     = 3'h7;
   localparam logic [2:0]  CODE_STEP         = 3'h1;

   // Level loop timing, in chip clocks
   localparam int          LOOP_CHIPS        = 16;
   localparam int          CHIPS_PER_BIT     = 8;
   localparam int          WIN_W             = 5;

   // Transmit-enable hold after the return to receive
   localparam int          CLK_MHZ           = 10;
   localparam int          TXEN_HOLD_NS      = 10000;
   localparam int          TXEN_HOLD_CYC     = (TXEN_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int          HOLD_W            = 8;

   // Interrupt bits
   localparam int          IRQ_W             = 3;
   localparam int          IRQ_OVERCURRENT   = 0;
   localparam int          IRQ_OVERTEMP      = 1;
   localparam int          IRQ_LOOP_DONE     = 2;
   localparam logic [2:0]  IRQ_MASK_RST      = 3'h0;

   // Status bits
   localparam int          ST_OC             = 3;
   localparam int          ST_OT             = 4;
   localparam int          ST_LOOP           = 5;
   localparam int          ST_TX             = 6;

   // Synchronised pin indices
   localparam int          SY_CHIP           = 0;
   localparam int          SY_BELOW          = 1;
   localparam int          SY_ABOVE          = 2;
   localparam int          SY_OC             = 3;
   localparam int          SY_OT             = 4;
   localparam int          SY_DRV            = 5;
   localparam int          SYNC_W            = 6;

   typedef enum logic [0:0] {PH_EVAL, PH_APPLY} loop_phase_t;

endpackage : tx_level_pkg

// >>> tb/line_driver_model.sv
`timescale 1ns/1ps
module line_driver_model (
   input  wire logic tx_pin_n,
   input  wire logic load_at_limit,
   input  wire logic junction_hot,
   output logic      driver_enable_n,
   output logic      overcurrent_flag,
   output logic      over_temp
);
   // Looped enable with pull-up: high unless the pin is pulled low
   assign driver_enable_n  = tx_pin_n ? 1'b1 : 1'b0;
   assign overcurrent_flag = load_at_limit;
   assign over_temp        = junction_hot;
endmodule : line_driver_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import tx_level_pkg::*;
   logic              clk      = 1'b0;
   logic              rst_n    = 1'b0;
   logic [ADDR_W-1:0] addr     = '0;
   logic [DATA_W-1:0] wr_data  = '0;
   logic              wr_en    = 1'b0;
   logic              rd_en    = 1'b0;
   logic              chip     = 1'b0;
   logic              below    = 1'b0;
   logic              above    = 1'b0;
   logic              at_lim   = 1'b0;
   logic              hot      = 1'b0;
   logic [DATA_W-1:0] rd_data;
   logic [CODE_W-1:0] code;
   logic [CODE_W-1:0] exp_code;
   logic              tx_out, tx_oe, tx_pin_n, drv_en_n, oc, ot, amp, irq;
   int                n_mismatch = 0;
   int                tests_run  = 0;
   int                cycles     = 0;

   // Open-drain pin with its pull-up
   assign tx_pin_n = tx_oe ? tx_out : 1'b1;

   tx_level_control #(.LOOP_LEN(LOOP_CHIPS), .HOLD_CYC(10)) dut (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .chip_clk_pin(chip), .peak_below_low(below),
      .peak_above_high(above), .overcurrent_flag(oc), .over_temp(ot),
      .driver_enable_n(drv_en_n), .attenuation_code(code),
      .transmit_active_n_out(tx_out), .transmit_active_n_oe(tx_oe),
      .amp_enable(amp), .irq(irq));

   line_driver_model drv (
      .tx_pin_n(tx_pin_n), .load_at_limit(at_lim), .junction_hot(hot),
      .driver_enable_n(drv_en_n), .overcurrent_flag(oc), .over_temp(ot));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic give_verdict;
      if (n_mismatch == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en   <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(what, exp, rd_data);
   endtask : rd

   // Slow chip clock: the pin is synchronised, so each phase lasts many clocks
   task automatic chip_edge;
      @(posedge clk);
      chip <= 1'b1;
      repeat (10) @(posedge clk);
      chip <= 1'b0;
      settle(9);
   endtask : chip_edge

   task automatic window(input logic up);
      wr(ADDR_MODE, 8'h01);
      for (int i = 0; i < LOOP_CHIPS / 2; i++) begin
         chip_edge();
         chk("code after evaluate", 8'(exp_code), 8'(code));
         chip_edge();
         if (up)
            exp_code = (exp_code == CODE_MIN_GAIN) ? exp_code : exp_code + CODE_STEP;
         else
            exp_code = (exp_code == CODE_MAX_GAIN) ? exp_code : exp_code - CODE_STEP;
         chk("code after apply", 8'(exp_code), 8'(code));
      end
      chk("tx pin active", 8'h00, 8'(tx_pin_n));
      chk("amp on", 8'h01, 8'(amp));
   endtask : window

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      settle(1);
      chk("code at reset", 8'(CODE_MIN_GAIN), 8'(code));
      chk("tx pin idle", 8'h01, 8'(tx_pin_n));
      chk("amp at reset", 8'h00, 8'(amp));
      rd(ADDR_LEVEL_CTRL, 8'h00, "level ctrl reset");
      rd(ADDR_IRQ_MASK, 8'h00, "mask reset");
      wr(3'h5, 8'hff);
      rd(3'h5, 8'h00, "unmapped");
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_LEVEL_CTRL, 8'(8 + c));
         rd(ADDR_LEVEL_CTRL, 8'(8 + c), "level ctrl");
         chk("fixed code", 8'(c), 8'(code));
      end
      // Fixed level must survive a live loop window
      wr(ADDR_LEVEL_CTRL, 8'h0d);
      below <= 1'b1;
      wr(ADDR_MODE, 8'h01);
      repeat (4) chip_edge();
      chk("fixed under loop", 8'h05, 8'(code));
      wr(ADDR_MODE, 8'h00);
      wr(ADDR_LEVEL_CTRL, 8'h00);
      wr(ADDR_IRQ_MASK, 8'h07);
      settle(20);
      exp_code = 3'h5;
      window(1'b0);
      rd(ADDR_IRQ_STATUS, 8'h04, "loop done");
      chk("irq loop done", 8'h01, 8'(irq));
      wr(ADDR_IRQ_STATUS, 8'h04);
      above <= 1'b1;
      below <= 1'b0;
      repeat (2) chip_edge();
      chk("code after window", 8'h00, 8'(code));
      chk("irq cleared", 8'h00, 8'(irq));
      @(posedge clk);
      hot <= 1'b1;
      settle(10);
      chk("amp when hot", 8'h00, 8'(amp));
      rd(ADDR_IRQ_STATUS, 8'h02, "overtemp event");
      @(posedge clk);
      hot <= 1'b0;
      settle(10);
      chk("amp cooled", 8'h01, 8'(amp));
      wr(ADDR_IRQ_STATUS, 8'h02);
      @(posedge clk);
      at_lim <= 1'b1;
      settle(10);
      rd(ADDR_STATUS, 8'h48, "status at limit");
      chk("irq overcurrent", 8'h01, 8'(irq));
      @(posedge clk);
      at_lim <= 1'b0;
      settle(10);
      rd(ADDR_STATUS, 8'h40, "status recovered");
      rd(ADDR_IRQ_STATUS, 8'h01, "overcurrent sticky");
      wr(ADDR_IRQ_MASK, 8'h00);
      settle(2);
      chk("irq masked", 8'h00, 8'(irq));
      wr(ADDR_IRQ_STATUS, 8'h01);
      rd(ADDR_IRQ_STATUS, 8'h00, "status cleared");
      wr(ADDR_MODE, 8'h00);
      settle(5);
      chk("tx hold", 8'h00, 8'(tx_pin_n));
      settle(20);
      chk("tx released", 8'h01, 8'(tx_pin_n));
      chk("amp off", 8'h00, 8'(amp));
      chk("code kept", 8'h00, 8'(code));
      window(1'b1);
      give_verdict();
   end
endmodule : testbench
